// ### core/otp_prog_pkg.sv
// Constants, timing counts and pin bundle for the OTP word programmer.
package otp_prog_pkg;

  // Clock and array geometry.
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 16;
  localparam int TIMER_W       = 16;
  localparam int ID_CODE_SELECT_BIT = 0;

  // Program pulse: nominal, with the window it must stay inside.
  localparam int PULSE_NOM_NS  = 50000;
  localparam int PULSE_MIN_NS  = 47500;
  localparam int PULSE_MAX_NS  = 52500;
  localparam int MAX_EXTRA_PULSES = 10;

  // Pin timing in nanoseconds.
  localparam int SETUP_NS      = 2000;
  localparam int HOLD_NS       = 2000;
  localparam int DATA_VALID_NS = 150;
  localparam int FLOAT_NS      = 130;
  localparam int SYNC_STAGES   = 2;

  // Least times round up to whole cycles, never below one.
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PULSE_NOM_CYC = PULSE_NOM_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYC     = ceil_cycles(SETUP_NS);
  localparam int HOLD_CYC      = ceil_cycles(HOLD_NS);
  localparam int FLOAT_CYC     = ceil_cycles(FLOAT_NS);
  // Data is sampled after the synchroniser, so its delay is added.
  localparam int DATA_WAIT_CYC = ceil_cycles(DATA_VALID_NS) + SYNC_STAGES;

  localparam logic [TIMER_W-1:0] ZERO_COUNT = 16'h0000;
  localparam logic [TIMER_W-1:0] ONE_COUNT  = 16'h0001;
  localparam logic [7:0]         ID_UPPER   = 8'h00;

  // Everything the programmer drives onto the device.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              data_oe;
    logic              program_pulse_n;
    logic              oe_n;
    logic              vcc_prog;
    logic              vpp_prog;
    logic              id_mode_address_line;
  } prog_pins_s;

endpackage

// ### core/otp_wait_timer.sv
// Down-counting wait timer used for every pin timing interval.
`timescale 1ns/1ps
module otp_wait_timer
  import otp_prog_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         cke,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              expired
);

  typedef struct packed {
    logic [W-1:0] count;
  } timer_s;

  timer_s s;
  timer_s next_s;

  // Load wins over counting; the count rests at zero.
  always_comb begin
    next_s = s;
    if (load) begin
      next_s.count = value;
    end else if (s.count != '0) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else if (cke) begin
      s <= next_s;
    end
  end

  assign expired = (s.count == '0);

endmodule // otp_wait_timer

// ### core/otp_programmer.sv
// Programmer for a word-wide OTP memory: program, verify, read-back, ID.
//
// Contract
// - Raise core to 6.5 V and program supply to 13 V, start at address zero.
// - First pass gives each word one 50 us program pulse, no verify; the code verifies after this pulse too.
// - Failing word gets up to ten more pulses, verify after each.
// - Word still failing after ten more pulses fails the whole part.
// - Verified word moves to next address until every address checked.
// - Drop both supplies to 5 V, re-read all words, report pass or fail.
// - Each program pulse is 50 us, held within 47.5 to 52.5 us.
// - Sample verify data no sooner than 150 ns after output enable falls.
`timescale 1ns/1ps
module otp_programmer
  import otp_prog_pkg::*;
#(
  parameter int                PULSE_CYCLES = PULSE_NOM_CYC,
  parameter logic [ADDR_W-1:0] LAST_ADDR    = 18'h3ffff,
  parameter logic [3:0]        MAX_PULSES   = 4'ha
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              cke,
  input  wire logic              start,
  input  wire logic              id_req,
  input  wire logic              id_select,
  output logic [ADDR_W-1:0]      src_addr,
  input  wire logic [DATA_W-1:0] src_data,
  output prog_pins_s             pins,
  input  wire logic [DATA_W-1:0] data_in,
  output logic                   busy,
  output logic                   done,
  output logic                   pass,
  output logic                   fail,
  output logic [DATA_W-1:0]      id_word,
  output logic                   id_valid
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_POWER, ST_SETUP, ST_PULSE, ST_HOLD, ST_OE_SETUP,
    ST_VERIFY, ST_FLOAT, ST_READ_SUPPLY, ST_READ_SETUP, ST_READ,
    ST_READ_FLOAT, ST_END
  } state_e;

  typedef struct packed {
    state_e              state;
    prog_pins_s          pins;
    logic [DATA_W-1:0]   sync1;
    logic [DATA_W-1:0]   sync2;
    logic [3:0]          extra;
    logic                word_ok;
    logic                id_run;
    logic                busy;
    logic                done;
    logic                pass;
    logic                fail;
    logic [DATA_W-1:0]   id_word;
    logic                id_valid;
    logic                tload;
    logic [TIMER_W-1:0]  tvalue;
  } ctrl_s;

  ctrl_s s;
  ctrl_s next_s;
  logic  expired;

  // A wait spends its load cycle and its expire cycle on top of the count.
  // So the pulse load is two short, which makes the strobe last exactly
  // PULSE_CYCLES cycles. The default keeps it inside the allowed window.
  localparam int                 WAIT_EXTRA = 2;
  localparam logic [TIMER_W-1:0] PULSE_LOAD =
    TIMER_W'(PULSE_CYCLES - WAIT_EXTRA);
  localparam logic [TIMER_W-1:0] SETUP_LOAD = TIMER_W'(SETUP_CYC);
  localparam logic [TIMER_W-1:0] HOLD_LOAD  = TIMER_W'(HOLD_CYC);
  localparam logic [TIMER_W-1:0] FLOAT_LOAD = TIMER_W'(FLOAT_CYC);
  localparam logic [TIMER_W-1:0] DATA_LOAD  = TIMER_W'(DATA_WAIT_CYC);

  otp_wait_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clock   (clock),
    .rstn    (rstn),
    .cke     (cke),
    .load    (s.tload),
    .value   (s.tvalue),
    .expired (expired)
  );

  // A wait is over only once the timer has taken the new load.
  logic wait_over;
  assign wait_over = expired && !s.tload;

  // Sequencer for program, verify, read-back and identification reads.
  always_comb begin
    next_s          = s;
    next_s.sync1    = data_in;
    next_s.sync2    = s.sync1;
    next_s.tload    = 1'b0;
    next_s.id_valid = 1'b0;
    unique case (s.state)
      ST_IDLE: begin
        if (start) begin
          next_s.pins.addr     = '0;
          next_s.pins.vcc_prog = 1'b1;
          next_s.pins.vpp_prog = 1'b1;
          next_s.extra  = '0;
          next_s.busy   = 1'b1;
          next_s.done   = 1'b0;
          next_s.pass   = 1'b0;
          next_s.fail   = 1'b0;
          next_s.tload  = 1'b1;
          next_s.tvalue = SETUP_LOAD;
          next_s.state  = ST_POWER;
        end else if (id_req) begin
          next_s.pins.addr = '0;
          next_s.pins.addr[ID_CODE_SELECT_BIT] = id_select;
          next_s.pins.id_mode_address_line = 1'b1;
          next_s.id_run = 1'b1;
          next_s.busy   = 1'b1;
          next_s.tload  = 1'b1;
          next_s.tvalue = SETUP_LOAD;
          next_s.state  = ST_READ_SETUP;
        end
      end
      ST_POWER: begin
        if (wait_over) begin
          next_s.pins.data_oe = 1'b1;
          next_s.tload  = 1'b1;
          next_s.tvalue = SETUP_LOAD;
          next_s.state  = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Data follows the source while the setup time runs out.
        next_s.pins.data    = src_data;
        next_s.pins.data_oe = 1'b1;
        if (wait_over) begin
          next_s.pins.program_pulse_n = 1'b0;
          next_s.tload  = 1'b1;
          next_s.tvalue = PULSE_LOAD;
          next_s.state  = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (wait_over) begin
          next_s.pins.program_pulse_n = 1'b1;
          next_s.tload  = 1'b1;
          next_s.tvalue = HOLD_LOAD;
          next_s.state  = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (wait_over) begin
          next_s.pins.data_oe = 1'b0;
          next_s.tload  = 1'b1;
          next_s.tvalue = SETUP_LOAD;
          next_s.state  = ST_OE_SETUP;
        end
      end
      ST_OE_SETUP: begin
        if (wait_over) begin
          next_s.pins.oe_n = 1'b0;
          next_s.tload  = 1'b1;
          next_s.tvalue = DATA_LOAD;
          next_s.state  = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        if (wait_over) begin
          next_s.word_ok   = (s.sync2 == s.pins.data);
          next_s.pins.oe_n = 1'b1;
          next_s.tload  = 1'b1;
          next_s.tvalue = FLOAT_LOAD;
          next_s.state  = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        if (wait_over) begin
          next_s.tload  = 1'b1;
          next_s.tvalue = SETUP_LOAD;
          if (s.word_ok && s.pins.addr == LAST_ADDR) begin
            next_s.pins.vcc_prog = 1'b0;
            next_s.pins.vpp_prog = 1'b0;
            next_s.state = ST_READ_SUPPLY;
          end else if (s.word_ok) begin
            next_s.pins.addr = s.pins.addr + 1'b1;
            next_s.extra = '0;
            next_s.state = ST_SETUP;
          end else if (s.extra == MAX_PULSES) begin
            next_s.fail  = 1'b1;
            next_s.state = ST_END;
          end else begin
            next_s.extra = s.extra + 1'b1;
            next_s.state = ST_SETUP;
          end
        end
      end
      ST_READ_SUPPLY: begin
        if (wait_over) begin
          next_s.pins.addr = '0;
          next_s.tload  = 1'b1;
          next_s.tvalue = SETUP_LOAD;
          next_s.state  = ST_READ_SETUP;
        end
      end
      ST_READ_SETUP: begin
        // The expected word is held in the idle data register.
        next_s.pins.data = src_data;
        if (wait_over) begin
          next_s.pins.program_pulse_n = 1'b0;
          next_s.pins.oe_n = 1'b0;
          next_s.tload  = 1'b1;
          next_s.tvalue = DATA_LOAD;
          next_s.state  = ST_READ;
        end
      end
      ST_READ: begin
        if (wait_over) begin
          if (s.id_run) begin
            next_s.id_word  = {ID_UPPER, s.sync2[7:0]};
            next_s.id_valid = 1'b1;
          end else if (s.sync2 != s.pins.data) begin
            next_s.fail = 1'b1;
          end
          next_s.pins.program_pulse_n = 1'b1;
          next_s.pins.oe_n = 1'b1;
          next_s.tload  = 1'b1;
          next_s.tvalue = FLOAT_LOAD;
          next_s.state  = ST_READ_FLOAT;
        end
      end
      ST_READ_FLOAT: begin
        if (wait_over) begin
          next_s.tload  = 1'b1;
          next_s.tvalue = SETUP_LOAD;
          if (s.id_run) begin
            next_s.pins.id_mode_address_line = 1'b0;
            next_s.id_run = 1'b0;
            next_s.busy   = 1'b0;
            next_s.state  = ST_IDLE;
          end else if (s.pins.addr == LAST_ADDR) begin
            next_s.state = ST_END;
          end else begin
            next_s.pins.addr = s.pins.addr + 1'b1;
            next_s.state = ST_READ_SETUP;
          end
        end
      end
      ST_END: begin
        // Supplies always return to read level, also after a failure.
        next_s.pins.vcc_prog = 1'b0;
        next_s.pins.vpp_prog = 1'b0;
        next_s.pins.data_oe  = 1'b0;
        next_s.busy  = 1'b0;
        next_s.done  = 1'b1;
        next_s.pass  = !s.fail;
        next_s.state = ST_IDLE;
      end
    endcase
  end

  // One register stage for all state; pins idle with strobes high.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '{state: ST_IDLE,
             pins: '{addr: '0, data: '0, data_oe: 1'b0,
                     program_pulse_n: 1'b1, oe_n: 1'b1,
                     vcc_prog: 1'b0, vpp_prog: 1'b0,
                     id_mode_address_line: 1'b0},
             sync1: '0, sync2: '0, extra: '0, word_ok: 1'b0,
             id_run: 1'b0, busy: 1'b0, done: 1'b0, pass: 1'b0,
             fail: 1'b0, id_word: '0, id_valid: 1'b0,
             tload: 1'b0, tvalue: ZERO_COUNT};
    end else if (cke) begin
      s <= next_s;
    end
  end

  assign src_addr = s.pins.addr;
  assign pins     = s.pins;
  assign busy     = s.busy;
  assign done     = s.done;
  assign pass     = s.pass;
  assign fail     = s.fail;
  assign id_word  = s.id_word;
  assign id_valid = s.id_valid;

endmodule // otp_programmer

// ### verif/otp_programmer_sva.sv
// Checker on the OTP programmer's pins and status flags.
`timescale 1ns/1ps
module otp_programmer_sva
  import otp_prog_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_NOM_CYC
) (
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              cke,
  input wire logic              start,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              pass,
  input wire logic              fail,
  input wire prog_pins_s        pins,
  input wire logic [DATA_W-1:0] id_word,
  input wire logic              id_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  int low_n;
  int oe_low;
  int hits;

  // Counts only enabled cycles, since a frozen clock stretches strobes.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_n <= 0;
      oe_low <= 0;
      hits <= 0;
    end else if (cke) begin
      low_n <= pins.program_pulse_n ? 0 : low_n + 1;
      oe_low <= pins.oe_n ? 0 : oe_low + 1;
      if (!$stable(pins.addr))
        hits <= 0;
      else if ($rose(pins.program_pulse_n) && pins.vpp_prog)
        hits <= hits + 1;
    end
  end

  // A run request taken in idle.
  sequence run_taken;
    start && !busy && cke;
  endsequence

  pulse_width_a: assert property ($rose(pins.program_pulse_n) &&
    pins.vpp_prog |-> low_n == PULSE_CYCLES) else $error("pulse width");
  pulse_supply_a: assert property (!pins.program_pulse_n && pins.oe_n
    |-> pins.vcc_prog && pins.vpp_prog && pins.data_oe) else $error("supply");
  run_start_a: assert property (run_taken |=> busy && pins.vcc_prog
    && pins.vpp_prog && pins.addr == '0) else $error("run start");
  verify_wait_a: assert property ($rose(pins.oe_n) |->
    oe_low >= DATA_VALID_NS / CLK_PERIOD_NS) else $error("early sample");
  no_fight_a: assert property (!pins.oe_n |-> !pins.data_oe)
    else $error("bus contention");
  pulse_budget_a: assert property (hits <= MAX_EXTRA_PULSES + 1)
    else $error("too many pulses");
  result_one_a: assert property ($rose(done) |-> pass != fail)
    else $error("verdict");
  id_upper_a: assert property (id_valid |-> id_word[15:8] == ID_UPPER)
    else $error("id upper byte");
endmodule // otp_programmer_sva

bind otp_programmer otp_programmer_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (
  .clock, .rstn, .cke, .start, .busy, .done, .pass, .fail, .pins, .id_word,
  .id_valid
);

// ### verif/otp_device_model.sv
// Behavioural OTP memory of four words with identification codes.
`timescale 1ns/1ps
module otp_device_model
  import otp_prog_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER_CODE = 16'h00a5, // Arbitrary value.
  parameter logic [DATA_W-1:0] TYPE_CODE  = 16'h005a  // Arbitrary value.
) (
  input  wire prog_pins_s        pins,
  input  wire logic [3:0]        need,
  input  wire logic              wipe,
  output logic [DATA_W-1:0]      data_out
);
  logic [DATA_W-1:0] mem [4];
  logic [3:0]        hits [4];
  logic [DATA_W-1:0] word;

  // A cell takes its data on the need-th pulse; above eleven it never does.
  always @(posedge pins.program_pulse_n or posedge wipe) begin
    if (wipe) begin
      for (int i = 0; i < 4; i++) begin
        mem[i] = 16'hffff;
        hits[i] = 4'h0;
      end
    end else if (pins.vpp_prog && pins.oe_n) begin
      hits[pins.addr[1:0]] = hits[pins.addr[1:0]] + 4'h1;
      if (hits[pins.addr[1:0]] == need)
        mem[pins.addr[1:0]] = pins.data;
    end
  end

  // The ID line high returns a code, address bit zero picking which.
  assign word = !pins.id_mode_address_line ? mem[pins.addr[1:0]] :
                pins.addr[0] ? TYPE_CODE : MAKER_CODE;

  // Data lags output enable; a released bus shows its last value inverted.
  always @(pins.oe_n) begin
    data_out = ~data_out;
    if (!pins.oe_n)
      #150 data_out = word;
  end
  initial data_out = 16'h0000;
endmodule // otp_device_model

// ### verif/otp_programmer_tb.sv
// Self-checking bench for the OTP programmer against a memory model.
`timescale 1ns/1ps
module otp_programmer_tb
  import otp_prog_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value.
  localparam logic [15:0] TYPE  = 16'h005a; // Arbitrary value.
  logic              clock, rstn, cke, start, id_req, id_select;
  logic              busy, done, pass, fail, id_valid, wipe;
  logic [ADDR_W-1:0] src_addr;
  logic [DATA_W-1:0] src_data, data_in, id_word;
  logic [3:0]        need;
  prog_pins_s        pins;
  int                failures = 0, n_checks = 0, npulse = 0, cyc = 0;

  otp_programmer #(.PULSE_CYCLES(20), .LAST_ADDR(18'h00003)) u_dut (
    .clock, .rstn, .cke, .start, .id_req, .id_select, .src_addr, .src_data,
    .pins, .data_in, .busy, .done, .pass, .fail, .id_word, .id_valid);
  otp_device_model #(.MAKER_CODE(MAKER), .TYPE_CODE(TYPE)) u_dev (
    .pins, .need, .wipe, .data_out(data_in));

  function automatic logic [15:0] pat(input logic [17:0] a);
    return 16'h5a00 ^ a[15:0];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Requests in a busy phase are dropped silently, so wait for idle first.
  task automatic wait_idle;
    while (busy !== 1'b0) begin
      @(posedge clock);
      #1;
    end
  endtask

  // One identification read with the given code select.
  task automatic id_read(input logic sel, input logic [15:0] exp);
    wait_idle();
    @(posedge clock);
    id_select <= sel;
    id_req <= 1'b1;
    @(posedge clock);
    id_req <= 1'b0;
    for (int i = 0; i < 3000 && id_valid !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk(id_word, exp);
  endtask

  // A full run where each model word needs n pulses to take.
  task automatic run(input logic [3:0] n, input logic ok);
    wait_idle();
    @(posedge clock);
    need <= n;
    wipe <= 1'b1;
    npulse = 0;
    @(posedge clock);
    wipe <= 1'b0;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
    #1;
    chk({pins.vcc_prog, pins.vpp_prog, pins.addr[13:0]}, 16'hc000);
    // A short freeze mid-run must not disturb the outcome.
    @(posedge clock);
    cke <= 1'b0;
    repeat (40) @(posedge clock);
    cke <= 1'b1;
    for (int i = 0; i < 60000 && busy !== 1'b0; i++)
      @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
    chk(16'({done, pass, fail}), ok ? 16'h0006 : 16'h0005);
    chk(16'(npulse), ok ? 16'(4 * n) : 16'h000b);
    if (ok) begin
      chk(16'({pins.vcc_prog, pins.vpp_prog}), 16'h0000);
      for (int i = 0; i < 4; i++)
        chk(u_dev.mem[i], pat(18'(i)));
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Source words follow the address one cycle later.
  always @(posedge clock)
    src_data <= pat(src_addr);

  always @(negedge pins.program_pulse_n)
    if (pins.vpp_prog)
      npulse++;

  // The four runs need about 52k cycles; a hang stops at the ceiling.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    {rstn, cke, start, id_req, id_select, wipe} = 6'h10;
    need = 4'h1;
    src_data = 16'h0000;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk(16'({pins.program_pulse_n, pins.oe_n, pins.vpp_prog, busy}), 16'h000c);
    id_read(1'b0, MAKER);
    id_read(1'b1, TYPE);
    run(4'h1, 1'b1);
    run(4'h3, 1'b1);
    run(4'hb, 1'b1);
    run(4'hc, 1'b0);
    report_and_stop();
  end
endmodule // otp_programmer_tb
